// [src/ssc_mib_counters.v]
// Function
// - Dynamic entry shown as nine bytes, 112-120
// - Bit 71 flags entry not yet ready
// - Thirty-two counters per port, two groups
// - Per-port word: zero, valid, 30-bit count
// - Port bases 0x00, 0x20, 0x40, 32 words
// - Receive octets, low and high priority
// - Short and long frames, good and bad
// - Symbol, checksum and fractional-byte errors
// - MAC control and qualified pause frames
// - Good broadcast, multicast, unicast received
// - Receive length histogram, bad frames included
// - Transmit good octets, pause included
// - Late collisions past 512 bit-times
// - Transmit pause, broadcast, multicast, unicast
// - Deferral and collision outcome counts
// - Six 16-bit drop counters at 0x100
// - Counters read from 117-120, per-port ones reread until valid
// - No overflow indication, counts wrap
// - Per-port clear on read, drops kept
// - Vacant flag and entry count minus one
`timescale 1ns/1ps
`include "ssc_mib_defs.vh"

module ssc_mib_counters #(
  parameter NPORT = 3,
  parameter NCNT = 32,
  parameter CNT_W = 30,
  parameter DROP_W = 16,
  parameter LEN_W = 11
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  input wire i_max_len_long,
  input wire [NPORT-1:0] i_rx_end,
  input wire [NPORT*LEN_W-1:0] i_rx_len,
  input wire [NPORT-1:0] i_rx_hi_prio,
  input wire [NPORT-1:0] i_rx_crc_bad,
  input wire [NPORT-1:0] i_rx_sym_err,
  input wire [NPORT-1:0] i_rx_frac,
  input wire [NPORT-1:0] i_rx_bcast,
  input wire [NPORT-1:0] i_rx_mcast,
  input wire [NPORT-1:0] i_rx_ctrl,
  input wire [NPORT-1:0] i_rx_pause,
  input wire [NPORT-1:0] i_tx_end,
  input wire [NPORT*LEN_W-1:0] i_tx_len,
  input wire [NPORT-1:0] i_tx_hi_prio,
  input wire [NPORT-1:0] i_tx_err,
  input wire [NPORT-1:0] i_tx_bcast,
  input wire [NPORT-1:0] i_tx_mcast,
  input wire [NPORT-1:0] i_tx_pause,
  input wire [NPORT-1:0] i_tx_one_col,
  input wire [NPORT-1:0] i_tx_multi_col,
  input wire [NPORT-1:0] i_tx_late_col,
  input wire [NPORT-1:0] i_tx_col,
  input wire [NPORT-1:0] i_tx_defer,
  input wire [NPORT-1:0] i_tx_excess,
  input wire [NPORT-1:0] i_tx_drop,
  input wire [NPORT-1:0] i_rx_drop,
  output reg o_dyn_req,
  output reg [9:0] o_dyn_index,
  input wire i_dyn_ack,
  input wire [55:0] i_dyn_entry,
  input wire [10:0] i_dyn_count
);

  localparam NWORD = NPORT * NCNT;
  localparam NDROP = 2 * NPORT;
  localparam ST_IDLE = 2'b00;
  localparam ST_CAP = 2'b01;
  localparam ST_DYN = 2'b10;

  reg [7:0] sel_r;
  reg [7:0] idx_r;
  reg [`SSC_DATA_W-1:0] data_r;
  reg [1:0] state_r;
  reg [CNT_W-1:0] mib_cnt_r [0:NWORD-1];
  reg [DROP_W-1:0] drop_cnt_r [0:NDROP-1];
  reg [`SSC_DATA_W-1:0] cap_word;
  reg [7:0] rd_byte;
  wire [NWORD-1:0] hit;
  wire [NWORD*CNT_W-1:0] amt;
  wire [NDROP-1:0] drop_hit;
  wire [8:0] mib_addr;
  wire [2:0] sel_grp;
  wire trig;
  wire clr_hit;
  wire [LEN_W-1:0] max_len;
  integer i, j;
  genvar p;
  genvar k;

  // ----------------------------------------------------------------
  // Indirect address decode
  // ----------------------------------------------------------------
  // Selection bit 0 extends the 8-bit offset to reach the drop group
  assign mib_addr = {sel_r[0], idx_r};
  assign sel_grp = sel_r[`SSC_SEL_GRP_HI:`SSC_SEL_GRP_LO];
  assign trig = i_reg_wr && (i_reg_addr == `SSC_REG_TRIG);
  // Only the per-port group is cleared by a read
  assign clr_hit = (state_r == ST_CAP) && (mib_addr < `SSC_PERPORT_LIMIT);
  // Oversize limit follows the maximum frame size setting
  assign max_len = i_max_len_long ? `SSC_LEN_MAX_LONG : `SSC_LEN_MAX_TAGGED;

  // ----------------------------------------------------------------
  // Per-port event classification
  // ----------------------------------------------------------------
  generate
    for (p = 0; p < NPORT; p = p + 1)
    begin : g_port
      wire [LEN_W-1:0] rl;
      wire [LEN_W-1:0] tl;
      wire re;
      wire rbad;
      wire rgood;
      wire rshort;
      wire rlong;
      wire rlegal;
      wire tok;
      wire [NCNT-1:0] h;
      assign rl = i_rx_len[p*LEN_W +: LEN_W];
      assign tl = i_tx_len[p*LEN_W +: LEN_W];
      assign re = i_rx_end[p];
      assign rbad = i_rx_crc_bad[p] | i_rx_sym_err[p] | i_rx_frac[p];
      assign rgood = re & ~rbad;
      assign rshort = rl < `SSC_LEN_MIN;
      assign rlong = rl > max_len;
      assign rlegal = ~rshort & ~rlong;
      assign tok = i_tx_end[p] & ~i_tx_err[p];

      // Receive octets count bad frames too
      assign h[`SSC_RX_LO_OCT] = re & ~i_rx_hi_prio[p];
      assign h[`SSC_RX_HI_OCT] = re & i_rx_hi_prio[p];
      // Size errors split by frame quality: checksum, symbol or fractional-byte error
      assign h[`SSC_RX_SHORT_GOOD] = rgood & rshort;
      assign h[`SSC_RX_SHORT_BAD] = re & rbad & rshort;
      assign h[`SSC_RX_LONG_GOOD] = rgood & rlong;
      assign h[`SSC_RX_LONG_BAD] = re & rbad & rlong;
      // Content errors on legal-size frames
      assign h[`SSC_RX_BAD_SYM] = re & i_rx_sym_err[p] & rlegal;
      assign h[`SSC_RX_CRC_FAIL] = re & rlegal & i_rx_crc_bad[p] & ~i_rx_frac[p];
      assign h[`SSC_RX_FRAC] = re & rlegal & i_rx_crc_bad[p] & i_rx_frac[p];
      // Pause needs the control type, opcode match, size and checksum
      assign h[`SSC_RX_MAC_CTRL] = re & i_rx_ctrl[p];
      assign h[`SSC_RX_PAUSE] = re & i_rx_ctrl[p] & i_rx_pause[p] & ~rshort &
                                ~i_rx_crc_bad[p];
      // Address class of good frames; broadcast wins over multicast
      assign h[`SSC_RX_BCAST] = rgood & i_rx_bcast[p];
      assign h[`SSC_RX_MCAST] = rgood & i_rx_mcast[p] & ~i_rx_bcast[p] &
                                ~i_rx_ctrl[p];
      assign h[`SSC_RX_UCAST] = rgood & ~i_rx_mcast[p] & ~i_rx_bcast[p];
      // Length histogram, bad frames included
      assign h[`SSC_RX_BIN_MIN] = re & (rl == `SSC_LEN_MIN);
      assign h[`SSC_RX_BIN_MIN+1] = re & (rl >= `SSC_LEN_B2) & (rl < `SSC_LEN_B3);
      assign h[`SSC_RX_BIN_MIN+2] = re & (rl >= `SSC_LEN_B3) & (rl < `SSC_LEN_B4);
      assign h[`SSC_RX_BIN_MIN+3] = re & (rl >= `SSC_LEN_B4) & (rl < `SSC_LEN_B5);
      assign h[`SSC_RX_BIN_MIN+4] = re & (rl >= `SSC_LEN_B5) & (rl < `SSC_LEN_B6);
      assign h[`SSC_RX_BIN_MIN+5] = re & (rl >= `SSC_LEN_B6) & ~rlong;
      // Transmit octets of good frames, pause frames among them
      assign h[`SSC_TX_LO_OCT] = tok & ~i_tx_hi_prio[p];
      assign h[`SSC_TX_HI_OCT] = tok & i_tx_hi_prio[p];
      // Late collision arrives as a pulse from the MAC
      assign h[`SSC_TX_LATE_COL] = i_tx_late_col[p];
      assign h[`SSC_TX_PAUSE] = tok & i_tx_pause[p];
      assign h[`SSC_TX_BCAST] = tok & i_tx_bcast[p];
      assign h[`SSC_TX_MCAST] = tok & i_tx_mcast[p] & ~i_tx_bcast[p];
      assign h[`SSC_TX_UCAST] = tok & ~i_tx_mcast[p] & ~i_tx_bcast[p];
      // Deferral and collision outcomes
      assign h[`SSC_TX_DEFER] = i_tx_defer[p];
      assign h[`SSC_TX_COL_TOTAL] = i_tx_col[p];
      assign h[`SSC_TX_EXCESS] = i_tx_excess[p];
      assign h[`SSC_TX_ONE_COL] = tok & i_tx_one_col[p];
      assign h[`SSC_TX_MULTI_COL] = tok & i_tx_multi_col[p];

      // Each port owns one window of NCNT words
      assign hit[p*`SSC_PORT_BASE_STRIDE +: NCNT] = h;

      // Octet words add the frame length, all others add one
      for (k = 0; k < NCNT; k = k + 1)
      begin : g_amt
        wire [CNT_W-1:0] len_ext;
        if (k == `SSC_RX_LO_OCT || k == `SSC_RX_HI_OCT)
        begin : g_rxo
          assign len_ext = {{(CNT_W-LEN_W){1'b0}}, rl};
        end
        else if (k == `SSC_TX_LO_OCT || k == `SSC_TX_HI_OCT)
        begin : g_txo
          assign len_ext = {{(CNT_W-LEN_W){1'b0}}, tl};
        end
        else
        begin : g_one
          assign len_ext = {{(CNT_W-1){1'b0}}, 1'b1};
        end
        assign amt[(p*NCNT+k)*CNT_W +: CNT_W] = hit[p*`SSC_PORT_BASE_STRIDE+k] ? len_ext :
                                                {CNT_W{1'b0}};
      end
    end
  endgenerate

  // Drop events: transmit ports first, then receive ports
  assign drop_hit = {i_rx_drop, i_tx_drop};

  // ----------------------------------------------------------------
  // Counter storage
  // ----------------------------------------------------------------
  // Clear and count in the same cycle keep the new event, so nothing is lost.
  // Counts wrap silently; the host tracks wrap-around itself.
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (i = 0; i < NWORD; i = i + 1)
        mib_cnt_r[i] <= {CNT_W{1'b0}};
    end
    else
    begin
      for (i = 0; i < NWORD; i = i + 1)
        mib_cnt_r[i] <= ((clr_hit && mib_addr[6:0] == i[6:0]) ? {CNT_W{1'b0}} :
                         mib_cnt_r[i]) + amt[i*CNT_W +: CNT_W];
    end
  end

  // Drop counters are never cleared by a read
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (j = 0; j < NDROP; j = j + 1)
        drop_cnt_r[j] <= {DROP_W{1'b0}};
    end
    else
    begin
      for (j = 0; j < NDROP; j = j + 1)
        drop_cnt_r[j] <= drop_cnt_r[j] + {{(DROP_W-1){1'b0}}, drop_hit[j]};
    end
  end

  // ----------------------------------------------------------------
  // Capture mux
  // ----------------------------------------------------------------
  // Unmapped offsets answer a valid zero rather than stale data
  always @*
  begin
    cap_word = `SSC_WORD_RESET;
    if (mib_addr < `SSC_PERPORT_LIMIT)
    begin
      cap_word[CNT_W-1:0] = mib_cnt_r[mib_addr[6:0]];
      cap_word[`SSC_WORD_VALID] = 1'b1;
    end
    else if (mib_addr >= `SSC_DROP_BASE && mib_addr <= `SSC_DROP_LIMIT)
      cap_word[DROP_W-1:0] = drop_cnt_r[mib_addr[2:0]];
    else
      cap_word[`SSC_WORD_VALID] = 1'b1;
  end

  // ----------------------------------------------------------------
  // Indirect access sequencer
  // ----------------------------------------------------------------
  // A trigger while a fetch is in flight is dropped; the host must wait
  // for the ready or valid flag before starting the next one.
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_r <= ST_IDLE;
      data_r <= `SSC_WORD_RESET;
      o_dyn_req <= 1'b0;
      o_dyn_index <= 10'h000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (trig && sel_grp == `SSC_SEL_GRP_MIB)
          begin
            data_r <= `SSC_WORD_RESET;
            state_r <= ST_CAP;
          end
          else if (trig && sel_grp == `SSC_SEL_GRP_DYN)
          begin
            data_r <= `SSC_WORD_RESET;
            data_r[`SSC_DYN_NOT_READY] <= 1'b1;
            o_dyn_req <= 1'b1;
            o_dyn_index <= {sel_r[1:0], i_reg_wdata};
            state_r <= ST_DYN;
          end
        end
        ST_CAP:
        begin
          data_r <= cap_word;
          state_r <= ST_IDLE;
        end
        ST_DYN:
        begin
          if (i_dyn_ack)
          begin
            o_dyn_req <= 1'b0;
            data_r[`SSC_DYN_NOT_READY] <= 1'b0;
            // Empty table reads vacant with a zero count field
            data_r[`SSC_DYN_VACANT] <= (i_dyn_count == 11'h000);
            data_r[`SSC_DYN_CNT_HI:`SSC_DYN_CNT_LO] <= (i_dyn_count == 11'h000) ? 10'h000 :
                             i_dyn_count[9:0] - 10'h001;
            data_r[`SSC_DYN_ENTRY_HI:0] <= i_dyn_entry;
            state_r <= ST_IDLE;
          end
        end
        default:
        begin
          state_r <= ST_IDLE;
          o_dyn_req <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Selection and trigger registers
  // ----------------------------------------------------------------
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sel_r <= 8'h00;
      idx_r <= 8'h00;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `SSC_REG_SEL)
        sel_r <= i_reg_wdata;
      if (i_reg_addr == `SSC_REG_TRIG)
        idx_r <= i_reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data bytes are laid out most significant first from the top register
  always @*
  begin
    rd_byte = 8'h00;
    if (i_reg_addr == `SSC_REG_SEL)
      rd_byte = sel_r;
    else if (i_reg_addr == `SSC_REG_TRIG)
      rd_byte = idx_r;
    else if (i_reg_addr >= `SSC_REG_DATA_TOP && i_reg_addr <= `SSC_REG_DATA_BOT)
      rd_byte = data_r[(`SSC_REG_DATA_BOT - i_reg_addr)*8 +: 8];
  end

  // Read data is registered, one cycle after the strobe
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end
    else
    begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd)
        o_reg_rdata <= rd_byte;
    end
  end

endmodule // ssc_mib_counters

// [src/ssc_mib_defs.vh]
`ifndef SSC_MIB_DEFS_VH
`define SSC_MIB_DEFS_VH

// ----------------------------------------------------------------
// Indirect access register numbers
// ----------------------------------------------------------------
`define SSC_REG_SEL 8'h6E
`define SSC_REG_TRIG 8'h6F
`define SSC_REG_DATA_TOP 8'h70
`define SSC_REG_DATA_BOT 8'h78

// ----------------------------------------------------------------
// Selection codes and address layout
// ----------------------------------------------------------------
`define SSC_SEL_DYN 8'h18
`define SSC_SEL_MIB 8'h1C
`define SSC_SEL_DROP 8'h1D
`define SSC_SEL_GRP_HI 4
`define SSC_SEL_GRP_LO 2
`define SSC_SEL_GRP_MIB 3'h7
`define SSC_SEL_GRP_DYN 3'h6
`define SSC_PORT_BASE_STRIDE 32
`define SSC_PERPORT_LIMIT 9'h060
`define SSC_DROP_BASE 9'h100
`define SSC_DROP_LIMIT 9'h105

// ----------------------------------------------------------------
// Word layouts
// ----------------------------------------------------------------
`define SSC_WORD_VALID 30
`define SSC_DYN_NOT_READY 71
`define SSC_DYN_VACANT 66
`define SSC_DYN_CNT_HI 65
`define SSC_DYN_CNT_LO 56
`define SSC_DYN_ENTRY_HI 55
`define SSC_DATA_W 72
`define SSC_WORD_RESET 72'h0

// ----------------------------------------------------------------
// Per-port counter offsets
// ----------------------------------------------------------------
`define SSC_RX_LO_OCT 0
`define SSC_RX_HI_OCT 1
`define SSC_RX_SHORT_GOOD 2
`define SSC_RX_SHORT_BAD 3
`define SSC_RX_LONG_GOOD 4
`define SSC_RX_LONG_BAD 5
`define SSC_RX_BAD_SYM 6
`define SSC_RX_CRC_FAIL 7
`define SSC_RX_FRAC 8
`define SSC_RX_MAC_CTRL 9
`define SSC_RX_PAUSE 10
`define SSC_RX_BCAST 11
`define SSC_RX_MCAST 12
`define SSC_RX_UCAST 13
`define SSC_RX_BIN_MIN 14
`define SSC_TX_LO_OCT 20
`define SSC_TX_HI_OCT 21
`define SSC_TX_LATE_COL 22
`define SSC_TX_PAUSE 23
`define SSC_TX_BCAST 24
`define SSC_TX_MCAST 25
`define SSC_TX_UCAST 26
`define SSC_TX_DEFER 27
`define SSC_TX_COL_TOTAL 28
`define SSC_TX_EXCESS 29
`define SSC_TX_ONE_COL 30
`define SSC_TX_MULTI_COL 31

// ----------------------------------------------------------------
// Frame length limits
// ----------------------------------------------------------------
`define SSC_LEN_MIN 11'd64
`define SSC_LEN_B2 11'd65
`define SSC_LEN_B3 11'd128
`define SSC_LEN_B4 11'd256
`define SSC_LEN_B5 11'd512
`define SSC_LEN_B6 11'd1024
`define SSC_LEN_MAX_LONG 11'd1536
`define SSC_LEN_MAX_TAGGED 11'd1522

`endif

// [dv/ssc_dyn_table_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Dynamic address table stand-in, answers fetches after a delay
// ----------------------------------------------------------------
module ssc_dyn_table_model #(
  parameter DELAY = 5
) (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_req,
  input wire [9:0] i_index,
  input wire [10:0] i_count,
  output reg o_ack,
  output reg [55:0] o_entry,
  output reg [10:0] o_count
);
  reg [3:0] wait_r;
  reg done_r;
  wire hit = i_req && !done_r && (wait_r == DELAY);

  // One acknowledge per request; outside it the lines toggle, never hold
  always @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wait_r <= 4'h0;
      done_r <= 1'b0;
      o_ack <= 1'b0;
      o_entry <= 56'h0;
      o_count <= 11'h0;
    end
    else
    begin
      o_ack <= hit;
      done_r <= i_req && (done_r || hit);
      wait_r <= (i_req && !done_r) ? wait_r + 4'h1 : 4'h0;
      o_entry <= hit ? {8'h5A, 38'h0, i_index} : ~o_entry;
      o_count <= hit ? i_count : ~o_count;
    end
  end
endmodule // ssc_dyn_table_model

// [dv/ssc_mib_monitor.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Port-level checks of the indirect access path
// ----------------------------------------------------------------
module ssc_mib_monitor (
  input wire i_ref_clk,
  input wire i_resetn,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  input wire [7:0] o_reg_rdata,
  input wire o_reg_rvalid,
  input wire o_dyn_req,
  input wire [9:0] o_dyn_index,
  input wire i_dyn_ack
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // Steps of a table fetch
  sequence s_trigger;
    i_reg_wr && i_reg_addr == 8'h6F;
  endsequence
  sequence s_read_top;
    i_reg_rd && i_reg_addr == 8'h70 && o_dyn_req && !i_dyn_ack;
  endsequence

  a_rvalid_after_read:
    assert property (i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
  a_rvalid_only_read:
    assert property (o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray read valid");
  a_rdata_held:
    assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata)) else $error("rdata moved");
  a_req_from_trigger:
    assert property ($rose(o_dyn_req) |-> $past(i_reg_wr && i_reg_addr == 8'h6F))
    else $error("fetch without trigger");
  a_req_index_taken:
    assert property ($rose(o_dyn_req) |-> o_dyn_index[7:0] == $past(i_reg_wdata))
    else $error("fetch index wrong");
  a_req_until_ack:
    assert property (o_dyn_req && !i_dyn_ack |=> o_dyn_req) else $error("fetch dropped");
  a_req_ends_ack:
    assert property (o_dyn_req && i_dyn_ack |=> !o_dyn_req) else $error("fetch stuck");
  a_not_ready_flag:
    assert property (s_read_top |=> o_reg_rdata[7]) else $error("ready flag early");
  a_unmapped_zero:
    assert property (i_reg_rd && (i_reg_addr > 8'h78 || i_reg_addr < 8'h6E)
      |=> o_reg_rdata == 8'h00) else $error("unmapped read nonzero");
  c_fetch: cover property (s_trigger ##1 o_dyn_req);
endmodule // ssc_mib_monitor

bind ssc_mib_counters ssc_mib_monitor u_mon (.i_ref_clk, .i_resetn, .i_reg_wr, .i_reg_rd,
  .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .o_dyn_req, .o_dyn_index,
  .i_dyn_ack);

// [dv/testbench.sv]
`timescale 1ns/1ps
`include "ssc_mib_defs.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t got %0h expected %0h", $time, a, e); end end
// ----------------------------------------------------------------
// Register-level tests of the counter bank
// ----------------------------------------------------------------
module testbench;
  reg i_ref_clk = 0, i_resetn = 0, i_reg_wr = 0, i_reg_rd = 0, i_max_len_long = 1;
  reg [7:0] i_reg_addr = 0, i_reg_wdata = 0, b;
  reg [2:0] i_rx_end = 0, i_rx_hi_prio = 0, i_rx_crc_bad = 0, i_rx_sym_err = 0;
  reg [2:0] i_rx_frac = 0, i_rx_bcast = 0, i_rx_mcast = 0, i_rx_ctrl = 0, i_rx_pause = 0;
  reg [2:0] i_tx_end = 0, i_tx_hi_prio = 0, i_tx_err = 0, i_tx_bcast = 0, i_tx_mcast = 0;
  reg [2:0] i_tx_pause = 0, i_tx_one_col = 0, i_tx_multi_col = 0, i_tx_late_col = 0;
  reg [2:0] i_tx_col = 0, i_tx_defer = 0, i_tx_excess = 0, i_tx_drop = 0, i_rx_drop = 0;
  reg [32:0] i_rx_len = 0, i_tx_len = 0;
  reg [10:0] dcnt = 0;
  wire [7:0] o_reg_rdata;
  wire o_reg_rvalid, o_dyn_req, i_dyn_ack;
  wire [9:0] o_dyn_index;
  wire [55:0] i_dyn_entry;
  wire [10:0] i_dyn_count;
  int num_errors = 0, check_count = 0;

  always #5 i_ref_clk = ~i_ref_clk;

  ssc_mib_counters dut (.i_ref_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_max_len_long, .i_rx_end, .i_rx_len,
    .i_rx_hi_prio, .i_rx_crc_bad, .i_rx_sym_err, .i_rx_frac, .i_rx_bcast, .i_rx_mcast,
    .i_rx_ctrl, .i_rx_pause, .i_tx_end, .i_tx_len, .i_tx_hi_prio, .i_tx_err, .i_tx_bcast,
    .i_tx_mcast, .i_tx_pause, .i_tx_one_col, .i_tx_multi_col, .i_tx_late_col, .i_tx_col,
    .i_tx_defer, .i_tx_excess, .i_tx_drop, .i_rx_drop, .o_dyn_req, .o_dyn_index,
    .i_dyn_ack, .i_dyn_entry, .i_dyn_count);
  ssc_dyn_table_model #(.DELAY(5)) u_dyn (.i_ref_clk, .i_resetn, .i_req(o_dyn_req),
    .i_index(o_dyn_index), .i_count(dcnt), .o_ack(i_dyn_ack), .o_entry(i_dyn_entry),
    .o_count(i_dyn_count));

  // ----------------------------------------------------------------
  // Access tasks: one-cycle strobes, read answer seen one edge later
  // ----------------------------------------------------------------
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge i_ref_clk) #1;
    {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
    @(posedge i_ref_clk) #1;
    i_reg_wr = 1'b0;
  end
  endtask

  task rd(input [7:0] a, output [7:0] d);
  begin
    @(posedge i_ref_clk) #1;
    {i_reg_rd, i_reg_addr} = {1'b1, a};
    @(posedge i_ref_clk) #1;
    i_reg_rd = 1'b0;
    `CHK(o_reg_rvalid, 1'b1)
    d = o_reg_rdata;
  end
  endtask

  // Counter fetch; drop words carry no valid flag so they are not reread
  task ctr(input drop, input [7:0] off, input [29:0] e);
    reg [31:0] w;
    int t;
  begin
    wr(`SSC_REG_SEL, drop ? `SSC_SEL_DROP : `SSC_SEL_MIB);
    wr(`SSC_REG_TRIG, off);
    t = 0;
    do rd(8'h75, w[31:24]); while (!drop && w[30] !== 1'b1 && ++t < 8);
    for (t = 1; t < 4; t++) rd(8'h75 + t[7:0], w[31 - 8 * t -: 8]);
    `CHK(w, drop ? {16'h0, e[15:0]} : {2'b01, e})
  end
  endtask

  task dy(input [9:0] x, input [10:0] c);
    reg [71:0] w;
    int t;
  begin
    dcnt = c;
    wr(`SSC_REG_SEL, `SSC_SEL_DYN | x[9:8]);
    wr(`SSC_REG_TRIG, x[7:0]);
    rd(8'h70, b);
    `CHK(b[7], 1'b1)
    for (t = 0; t < 40 && b[7] !== 1'b0; t++) rd(8'h70, b);
    w[71:64] = b;
    for (t = 1; t < 9; t++) rd(8'h70 + t[7:0], w[71 - 8 * t -: 8]);
    `CHK(w, {5'h0, c == 0, c == 0 ? 10'h0 : 10'(c - 1), 8'h5A, 38'h0, x})
  end
  endtask

  // Frame end strobes with their qualifiers, one frame per call
  task rxf(input int p, input [10:0] l, input [7:0] f);
  begin
    @(posedge i_ref_clk) #1;
    {i_rx_end[p], i_rx_len[p * 11 +: 11]} = {1'b1, l};
    {i_rx_pause[p], i_rx_ctrl[p], i_rx_mcast[p], i_rx_bcast[p], i_rx_frac[p],
      i_rx_sym_err[p], i_rx_crc_bad[p], i_rx_hi_prio[p]} = f;
    @(posedge i_ref_clk) #1;
    i_rx_end = 3'h0;
  end
  endtask

  task txf(input int p, input [10:0] l, input [6:0] f);
  begin
    @(posedge i_ref_clk) #1;
    {i_tx_end[p], i_tx_len[p * 11 +: 11]} = {1'b1, l};
    {i_tx_multi_col[p], i_tx_one_col[p], i_tx_pause[p], i_tx_mcast[p], i_tx_bcast[p],
      i_tx_err[p], i_tx_hi_prio[p]} = f;
    @(posedge i_ref_clk) #1;
    i_tx_end = 3'h0;
  end
  endtask

  task end_of_test;
  begin
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the sequence needs
  initial
  begin
    #200000;
    num_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    #1 i_resetn = 1'b1;
    rd(8'h10, b);
    `CHK(b, 8'h00)
    ctr(0, 8'h00, 0);
    rxf(0, 11'd60, 8'h00);
    rxf(0, 11'd64, 8'h00);
    rxf(1, 11'd100, 8'h11);
    rxf(2, 11'd1530, 8'h02);
    rxf(2, 11'd1530, 8'h0A);
    i_max_len_long = 1'b0;
    rxf(2, 11'd1530, 8'h02);
    // Counters read back right after the traffic
    ctr(0, 8'h00, 124);
    ctr(0, 8'h00, 0);
    ctr(0, 8'h02, 1);
    ctr(0, 8'h0E, 1);
    ctr(0, 8'h20, 0);
    ctr(0, 8'h21, 100);
    ctr(0, 8'h2B, 1);
    ctr(0, 8'h2D, 0);
    ctr(0, 8'h2F, 1);
    ctr(0, 8'h47, 1);
    ctr(0, 8'h48, 1);
    ctr(0, 8'h45, 1);
    ctr(0, 8'h53, 2);
    ctr(0, 8'h60, 0);
    rxf(0, 11'd64, 8'hC0);
    ctr(0, 8'h09, 1);
    ctr(0, 8'h0A, 1);
    txf(0, 11'd200, 7'h05);
    txf(0, 11'd64, 7'h18);
    txf(0, 11'd100, 7'h20);
    @(posedge i_ref_clk) #1;
    {i_tx_late_col, i_tx_col, i_tx_defer, i_tx_excess} = 12'h249;
    {i_tx_drop, i_rx_drop} = 6'b010_100;
    @(posedge i_ref_clk) #1;
    {i_tx_late_col, i_tx_col, i_tx_defer, i_tx_excess} = 12'h000;
    {i_tx_drop, i_rx_drop} = 6'b010_000;
    @(posedge i_ref_clk) #1;
    {i_tx_drop, i_rx_drop} = 6'b000_000;
    ctr(0, 8'h15, 200);
    ctr(0, 8'h14, 164);
    ctr(0, 8'h17, 1);
    ctr(0, 8'h18, 1);
    ctr(0, 8'h19, 1);
    ctr(0, 8'h1A, 1);
    ctr(0, 8'h1E, 1);
    ctr(0, 8'h1F, 0);
    ctr(0, 8'h16, 1);
    ctr(0, 8'h1B, 1);
    ctr(0, 8'h1C, 1);
    ctr(0, 8'h1D, 1);
    ctr(1, 8'h01, 2);
    ctr(1, 8'h01, 2);
    ctr(1, 8'h05, 1);
    dy(10'h205, 11'd37);
    dy(10'h000, 11'd0);
    end_of_test();
  end
endmodule // testbench
